// ==== common/boot_table_pkg.sv ====
// boot table interpreter constants: field sizes, reserved port codes,
// working-state word addresses and reset values.
// assumes a byte stream source and a single 50 MHz processor clock.
package boot_table_pkg;

    // ************************************************************
    // table layout
    // ************************************************************
    localparam int        FIELD_BYTES     = 4;
    localparam logic [15:0] DELAY_TAG     = 16'hFFFF;
    localparam logic [15:0] RESV_LOW      = 16'hFFF0;
    localparam logic [15:0] WRITE_LIMIT   = 16'hFFEF;
    localparam logic [31:0] END_COUNT     = 32'h0000_0000;

    // ************************************************************
    // working-state word addresses held while loading
    // ************************************************************
    localparam logic [15:0] ENTRY_WORD_HI = 16'h0060;
    localparam logic [15:0] ENTRY_WORD_LO = 16'h0061;
    localparam logic [15:0] STACK_WORD    = 16'h0090;
    localparam logic [15:0] SYS_STACK_WORD = 16'h0080;
    localparam logic [23:0] GUARD_BYTE_END = 24'h000200;

    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [31:0] ENTRY_RESET   = 32'h0000_0000;
    localparam int          CLK_MHZ       = 50;
    localparam int          WRITE_WAIT_CYC = 1;

    typedef enum logic [3:0] {
        ST_ENTRY   = 4'h0,
        ST_COUNT   = 4'h1,
        ST_CONFIG  = 4'h3,
        ST_PWRITE  = 4'h2,
        ST_PWAIT   = 4'h6,
        ST_DELAY   = 4'h7,
        ST_SECLEN  = 4'h5,
        ST_SECDST  = 4'h4,
        ST_DATA    = 4'hC,
        ST_DONE    = 4'hD
    } load_state_e;

endpackage

// ==== hw/boot_table_interpreter.sv ====
// boot table interpreter: walks entry, config list and sections.
// assumes one upstream byte source (valid/ready) and a memory/port
// write side that completes a port write in one cycle.
`timescale 1ns/10ps
module boot_table_interpreter (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // byte stream from any boot source
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteData,
    output logic             byteReady,
    // peripheral port write
    output logic             portWrite,
    output logic [15:0]      portAddr,
    output logic [15:0]      portData,
    // section byte writes
    output logic             memWrite,
    output logic [23:0]      memAddr,
    output logic [7:0]       memData,
    // working-state word writes
    output logic             stateWrite,
    output logic [15:0]      stateAddr,
    output logic [15:0]      stateData,
    // hand over
    output logic             bootDone,
    output logic [31:0]      entryAddr,
    output logic             delayBusy
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        boot_table_pkg::load_state_e st;
        logic [31:0] entry;
        logic [31:0] cfgLeft;
        logic [23:0] secLeft;
        logic [23:0] dest;
        logic        leadPad;
        logic        trailPad;
        logic        firstByte;
        logic [15:0] pAddr;
        logic [15:0] pData;
        logic        pWrite;
        logic        dLoad;
        logic [15:0] dLen;
        logic        mWrite;
        logic [23:0] mAddr;
        logic [7:0]  mData;
        logic [1:0]  sIdx;
        logic        sWrite;
        logic [15:0] sAddr;
        logic [15:0] sData;
        logic        done;
    } ldr_s;

    ldr_s cur_q;
    ldr_s cur_d;

    logic        fieldStart;
    logic        fieldDone;
    logic [31:0] fieldWord;
    logic        dlyDone;
    logic        dlyBusy;
    logic        streamState;
    logic        byteTake;
    logic        lastByte;
    logic        padByte;

    // ************************************************************
    // byte intake and field assembly
    // ************************************************************
    // the same field walk serves every source: nothing here depends on
    // where the bytes come from
    assign streamState = (cur_q.st == boot_table_pkg::ST_ENTRY)  ||
                         (cur_q.st == boot_table_pkg::ST_COUNT)  ||
                         (cur_q.st == boot_table_pkg::ST_CONFIG) ||
                         (cur_q.st == boot_table_pkg::ST_SECLEN) ||
                         (cur_q.st == boot_table_pkg::ST_SECDST) ||
                         (cur_q.st == boot_table_pkg::ST_DATA);
    // no stream bytes while the working-state words are being written
    assign byteReady  = streamState && !cur_q.sWrite;
    assign byteTake   = byteValid && byteReady;
    assign fieldStart = !reset_n;

    field_assembler u_field (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .start     (fieldStart),
        .byteValid (byteTake && (cur_q.st != boot_table_pkg::ST_DATA)),
        .byteData  (byteData),
        .fieldDone (fieldDone),
        .fieldWord (fieldWord)
    );

    cycle_delay #(.WIDTH(16)) u_delay (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .load    (cur_q.dLoad),
        .length  (cur_q.dLen),
        .busy    (dlyBusy),
        .done    (dlyDone)
    );

    // pad bytes: a lead pad on an odd start, a trail pad on an even end
    assign lastByte = (cur_q.secLeft == 24'h1);
    assign padByte  = (cur_q.firstByte && cur_q.leadPad) ||
                      (lastByte && cur_q.trailPad);

    // ************************************************************
    // table walk
    // ************************************************************
    always_comb begin
        cur_d        = cur_q;
        cur_d.pWrite = 1'b0;
        cur_d.dLoad  = 1'b0;
        cur_d.mWrite = 1'b0;
        cur_d.sWrite = 1'b0;
        // working-state words go out one per cycle after the entry field
        if (cur_q.sIdx != 2'h0) begin
            cur_d.sWrite = 1'b1;
            cur_d.sIdx   = cur_q.sIdx + 2'h1;
            case (cur_q.sIdx)
                2'h1: begin
                    cur_d.sAddr = boot_table_pkg::ENTRY_WORD_LO;
                    cur_d.sData = cur_q.entry[15:0];
                end
                2'h2: begin
                    cur_d.sAddr = boot_table_pkg::STACK_WORD;
                    cur_d.sData = boot_table_pkg::STACK_WORD;
                end
                2'h3: begin
                    cur_d.sAddr = boot_table_pkg::SYS_STACK_WORD;
                    cur_d.sData = boot_table_pkg::SYS_STACK_WORD;
                end
                default: begin
                    cur_d.sWrite = 1'b0;
                end
            endcase
        end
        case (cur_q.st)
            boot_table_pkg::ST_ENTRY: begin
                if (fieldDone) begin
                    cur_d.entry = fieldWord;
                    cur_d.sWrite = 1'b1;
                    cur_d.sAddr = boot_table_pkg::ENTRY_WORD_HI;
                    cur_d.sData = fieldWord[31:16];
                    cur_d.sIdx  = 2'h1;
                    cur_d.st    = boot_table_pkg::ST_COUNT;
                end
            end
            boot_table_pkg::ST_COUNT: begin
                if (fieldDone) begin
                    cur_d.cfgLeft = fieldWord;
                    cur_d.st = (fieldWord == 32'h0) ?
                        boot_table_pkg::ST_SECLEN :
                        boot_table_pkg::ST_CONFIG;
                end
            end
            boot_table_pkg::ST_CONFIG: begin
                if (fieldDone) begin
                    cur_d.cfgLeft = cur_q.cfgLeft - 32'h1;
                    if (fieldWord[31:16] == boot_table_pkg::DELAY_TAG) begin
                        cur_d.dLoad = 1'b1;
                        cur_d.dLen  = fieldWord[15:0];
                        cur_d.st    = boot_table_pkg::ST_DELAY;
                    end else if (fieldWord[31:16] <
                                 boot_table_pkg::WRITE_LIMIT) begin
                        // value goes out unchecked
                        cur_d.pAddr  = fieldWord[31:16];
                        cur_d.pData  = fieldWord[15:0];
                        cur_d.pWrite = 1'b1;
                        cur_d.st     = boot_table_pkg::ST_PWRITE;
                    end else begin
                        // reserved codes: skipped, no strobe
                        cur_d.st = (cur_q.cfgLeft == 32'h1) ?
                            boot_table_pkg::ST_SECLEN :
                            boot_table_pkg::ST_CONFIG;
                    end
                end
            end
            boot_table_pkg::ST_PWRITE: begin
                cur_d.st = boot_table_pkg::ST_PWAIT;
            end
            boot_table_pkg::ST_PWAIT, boot_table_pkg::ST_DELAY: begin
                // next entry only after the current one finishes
                if (cur_q.st == boot_table_pkg::ST_PWAIT || dlyDone) begin
                    cur_d.st = (cur_q.cfgLeft == 32'h0) ?
                        boot_table_pkg::ST_SECLEN :
                        boot_table_pkg::ST_CONFIG;
                end
            end
            boot_table_pkg::ST_SECLEN: begin
                if (fieldDone) begin
                    cur_d.secLeft = fieldWord[23:0];
                    cur_d.st = (fieldWord == boot_table_pkg::END_COUNT) ?
                        boot_table_pkg::ST_DONE :
                        boot_table_pkg::ST_SECDST;
                end
            end
            boot_table_pkg::ST_SECDST: begin
                if (fieldDone) begin
                    cur_d.dest      = fieldWord[23:0];
                    cur_d.leadPad   = fieldWord[0];
                    // header count is real bytes only; the pads ride on
                    // top, so the end parity must come from count and dest
                    cur_d.trailPad  = fieldWord[0] ^ cur_q.secLeft[0];
                    cur_d.secLeft   = cur_q.secLeft + 24'(fieldWord[0]) +
                                      24'(fieldWord[0] ^ cur_q.secLeft[0]);
                    cur_d.firstByte = 1'b1;
                    cur_d.st        = boot_table_pkg::ST_DATA;
                end
            end
            boot_table_pkg::ST_DATA: begin
                if (byteTake) begin
                    cur_d.firstByte = 1'b0;
                    cur_d.secLeft   = cur_q.secLeft - 24'h1;
                    if (!padByte) begin
                        cur_d.mWrite = 1'b1;
                        cur_d.mAddr  = cur_q.dest;
                        cur_d.mData  = byteData;
                        cur_d.dest   = cur_q.dest + 24'h1;
                    end
                    if (lastByte) begin
                        cur_d.st = boot_table_pkg::ST_SECLEN;
                    end
                end
            end
            boot_table_pkg::ST_DONE: begin
                cur_d.done = 1'b1;
            end
            default: begin
                cur_d.st = boot_table_pkg::ST_ENTRY;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cur_q       <= '0;
            cur_q.st    <= boot_table_pkg::ST_ENTRY;
            cur_q.entry <= boot_table_pkg::ENTRY_RESET;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign portWrite  = cur_q.pWrite;
    assign portAddr   = cur_q.pAddr;
    assign portData   = cur_q.pData;
    assign memWrite   = cur_q.mWrite;
    assign memAddr    = cur_q.mAddr;
    assign memData    = cur_q.mData;
    assign stateWrite = cur_q.sWrite;
    assign stateAddr  = cur_q.sAddr;
    assign stateData  = cur_q.sData;
    assign bootDone   = cur_q.done;
    assign entryAddr  = cur_q.entry;
    assign delayBusy  = dlyBusy;

    // ************************************************************
    // checks
    // ************************************************************
    port_range_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        portWrite |-> portAddr < boot_table_pkg::WRITE_LIMIT)
        else $error("reserved port written");
    port_wait_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        portWrite |=> !byteReady ##1 !portWrite)
        else $error("port write not followed by wait");
    delay_nowrite_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        delayBusy |-> !portWrite && !memWrite && !byteReady)
        else $error("activity during delay");
    mem_seq_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        memWrite && !cur_q.firstByte && $past(memWrite) &&
        cur_q.st == boot_table_pkg::ST_DATA
        |-> memAddr == $past(memAddr) + 24'h1)
        else $error("section bytes not consecutive");
    zero_count_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        cur_q.st == boot_table_pkg::ST_COUNT && fieldDone &&
        fieldWord == 32'h0 |=> cur_q.st == boot_table_pkg::ST_SECLEN)
        else $error("zero count not skipped");
    end_table_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        cur_q.st == boot_table_pkg::ST_SECLEN && fieldDone &&
        fieldWord == 32'h0 |=> ##1 bootDone && !byteReady)
        else $error("end of table not handed over");
    no_early_sec_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        memWrite |-> cur_q.cfgLeft == 32'h0 && !delayBusy)
        else $error("section before config done");
    entry_hold_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        cur_q.st != boot_table_pkg::ST_ENTRY && $past(cur_q.st) !=
        boot_table_pkg::ST_ENTRY |-> $stable(entryAddr))
        else $error("entry address changed");
    entry_word_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        stateWrite && stateAddr == boot_table_pkg::ENTRY_WORD_HI
        |=> stateWrite && stateAddr == boot_table_pkg::ENTRY_WORD_LO)
        else $error("entry words not stored");

    cfg_write_c : cover property (@(posedge ref_clk) portWrite);
    delay_run_c : cover property (@(posedge ref_clk) $rose(delayBusy));
    sec_byte_c  : cover property (@(posedge ref_clk) memWrite);
    done_c      : cover property (@(posedge ref_clk) $rose(bootDone));
endmodule

// ==== hw/cycle_delay.sv ====
// counts a programmed number of processor cycles, then pulses done.
// assumes load is a single pulse and length is 1..65535.
`timescale 1ns/10ps
module cycle_delay #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] length,
    output logic                  busy,
    output logic                  done
);
    initial begin
        if (WIDTH < 2) $error("delay width too small");
    end

    typedef struct packed {
        logic [WIDTH-1:0] left;
        logic             run;
    } dly_s;

    dly_s cur_q;
    dly_s cur_d;

    assign busy = cur_q.run;
    assign done = cur_q.run && (cur_q.left == WIDTH'(1));

    // a length of n holds busy for exactly n cycles
    always_comb begin
        cur_d = cur_q;
        if (load) begin
            cur_d.left = length;
            cur_d.run  = (length != '0);
        end else if (cur_q.run) begin
            cur_d.left = cur_q.left - WIDTH'(1);
            cur_d.run  = (cur_q.left != WIDTH'(1));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_d;
        end
    end

    delay_ends_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        done |=> !busy) else $error("delay ran past its end");
endmodule

// ==== hw/field_assembler.sv ====
// gathers a 32-bit field from consecutive stream bytes, msb first.
// assumes byteValid is from the same clock; start clears the byte count.
`timescale 1ns/10ps
module field_assembler (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteData,
    output logic             fieldDone,
    output logic [31:0]      fieldWord
);
    typedef struct packed {
        logic [31:0] word;
        logic [2:0]  cnt;
    } asm_s;

    asm_s cur_q;
    asm_s cur_d;
    logic take;

    // a byte is consumed only when valid; fourth byte completes field
    assign take      = byteValid && !start;
    assign fieldDone = take && (cur_q.cnt == 3'h3);
    assign fieldWord = {cur_q.word[23:0], byteData};

    // next-state shifter
    always_comb begin
        cur_d = cur_q;
        if (start) begin
            cur_d.cnt = 3'h0;
        end else if (take) begin
            cur_d.word = {cur_q.word[23:0], byteData};
            cur_d.cnt  = (cur_q.cnt == 3'h3) ? 3'h0 : cur_q.cnt + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_d;
        end
    end

    count_bound_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        cur_q.cnt <= 3'h3) else $error("byte count out of range");
endmodule

// ==== tb/byte_source.sv ====
// partner model: boot source handing table bytes to the loader.
// assumes the bench fills q after reset; drives on the falling edge.
`timescale 1ns/10ps
module byte_source (
    input  wire logic       ref_clk,
    input  wire logic       byteReady,
    input  wire logic       stallEn,
    output logic            byteValid,
    output logic [7:0]      byteData
);
    logic [7:0] q[$];
    logic       taken;

    initial begin
        byteValid = 1'b0;
        byteData = 8'h00;
        taken = 1'b0;
    end

    // note whether the offer was taken at the rising edge
    always @(posedge ref_clk) begin
        taken <= byteValid && byteReady;
    end

    // an offer holds until taken; an idle line inverts its data every cycle
    always @(negedge ref_clk) begin
        if (taken && q.size() > 0) begin
            void'(q.pop_front());
        end
        if (byteValid && !taken && q.size() > 0) begin
            byteValid = 1'b1;
        end else if (q.size() > 0 && !(stallEn && $urandom_range(2) == 0)) begin
            byteValid = 1'b1;
            byteData = q[0];
        end else begin
            byteValid = 1'b0;
            byteData = ~byteData;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the boot table interpreter.
// assumes byte_source as the boot source; one 50 MHz clock.
`timescale 1ns/10ps
module testbench;
    typedef struct {int k; logic [31:0] a; logic [31:0] d;} ev_s;
    logic        ref_clk, reset_n, stallEn, byteValid, byteReady;
    logic        portWrite, memWrite, stateWrite, bootDone, delayBusy;
    logic [7:0]  byteData, memData;
    logic [15:0] portAddr, portData, stateAddr, stateData;
    logic [23:0] memAddr;
    logic [31:0] entryAddr, ent;
    ev_s         exq[$];
    int          n_mismatch = 0, compares = 0, cyc = 0, nc;
    logic [16:0] runLen = 0;
    logic        doneSeen = 0;

    boot_table_interpreter DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady),
        .portWrite(portWrite), .portAddr(portAddr), .portData(portData),
        .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
        .stateWrite(stateWrite), .stateAddr(stateAddr),
        .stateData(stateData), .bootDone(bootDone),
        .entryAddr(entryAddr), .delayBusy(delayBusy));
    byte_source src (.ref_clk(ref_clk), .byteReady(byteReady),
        .stallEn(stallEn), .byteValid(byteValid), .byteData(byteData));

    always #10 ref_clk = ~ref_clk;

    // ************************************************************
    // checking
    // ************************************************************
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (e !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // every visible action must match the next expected one, in order
    task chk_ev(input int k, input logic [31:0] a, input logic [31:0] d);
        ev_s e;
        e = '{-1, 0, 0};
        if (exq.size() > 0) e = exq.pop_front();
        cmp("kind", e.k, k);
        cmp("addr", e.a, a);
        cmp("data", e.d, d);
    endtask

    // delay length is measured as the run of busy cycles
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            doneSeen = 0;
            runLen = 0;
        end else begin
            if (stateWrite === 1'b1) chk_ev(0, stateAddr, stateData);
            if (portWrite === 1'b1) chk_ev(1, portAddr, portData);
            if (memWrite === 1'b1) chk_ev(3, memAddr, memData);
            if (delayBusy === 1'b1) begin
                runLen++;
                cmp("readyInDelay", 0, byteReady);
            end else if (runLen != 0) begin
                chk_ev(2, 0, runLen);
                runLen = 0;
            end
            if (bootDone === 1'b1 && !doneSeen) begin
                chk_ev(4, entryAddr, 0);
                doneSeen = 1;
            end
        end
    end

    // hang guard: far above the thousand or so cycles all six tables need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ************************************************************
    // table producer
    // ************************************************************
    task ex(input int k, input logic [31:0] a, input logic [31:0] d);
        exq.push_back('{k, a, d});
    endtask

    task put(input logic [31:0] v);
        for (int i = 3; i >= 0; i--) src.q.push_back(v[8*i+:8]);
    endtask

    task head(input logic [31:0] e, input logic [31:0] cnt);
        put(e);
        ex(0, 32'h0060, e[31:16]);
        ex(0, 32'h0061, e[15:0]);
        ex(0, 32'h0090, 32'h0090);
        ex(0, 32'h0080, 32'h0080);
        put(cnt);
    endtask

    task cfg(input logic [15:0] pa, input logic [15:0] pv);
        put({pa, pv});
        if (pa == 16'hFFFF) ex(2, 0, pv);
        else if (pa < 16'hFFEF) ex(1, pa, pv);
    endtask

    // pads: lead when start is odd, trail when last address is even
    task sec(input logic [23:0] d, input int n);
        logic [7:0] b;
        put(n);
        put(d);
        if (d[0]) src.q.push_back(8'hA5);
        for (int i = 0; i < n; i++) begin
            b = $urandom;
            src.q.push_back(b);
            ex(3, d + i, b);
        end
        if (d[0] != n[0]) src.q.push_back(8'h5A);
    endtask

    // junk after the end marker must stay unread
    task fin(input logic [31:0] e);
        int w;
        put(32'h0);
        put(32'h12345678);
        ex(4, e, 0);
        w = 0;
        while (bootDone !== 1'b1 && w < 4000) begin
            @(negedge ref_clk);
            w++;
        end
        cmp("bootDone", 1, bootDone);
        repeat (6) @(negedge ref_clk);
        cmp("pending", 0, exq.size());
        cmp("leftBytes", 4, src.q.size());
    endtask

    task rst;
        @(posedge ref_clk);
        src.q.delete();
        exq.delete();
        @(negedge ref_clk);
        reset_n = 1'b0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        @(posedge ref_clk);
        ent = $urandom;
    endtask

    task end_of_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        stallEn = 1'b0;
        void'($urandom(32'h2BE4E9C4));
        // reserved codes, write boundary, shortest delay, all pad cases
        rst();
        head(ent, 6);
        cfg(16'h1C00, 16'h2180);
        cfg(16'hFFFF, 16'h0001);
        cfg(16'hFFF5, 16'h1111);
        cfg(16'hFFEF, 16'h2222);
        cfg(16'hFFEE, 16'h3333);
        cfg(16'hFFFF, 16'h0010);
        sec(24'h000301, 3);
        sec(24'h000400, 2);
        sec(24'h000500, 3);
        sec(24'h000601, 4);
        fin(ent);
        // no entries, paced source, top of the address range
        stallEn = 1'b1;
        rst();
        head(ent, 0);
        sec(24'hFFFFFA, 5);
        fin(ent);
        // random tables
        repeat (4) begin
            rst();
            stallEn = $urandom_range(1);
            nc = $urandom_range(3);
            head(ent, nc);
            repeat (nc) begin
                if ($urandom_range(1)) cfg(16'hFFFF, $urandom_range(30, 1));
                // targets never reach the source's port or chip-select space
                else cfg($urandom_range(16'hFFEE),
                         $urandom);
            end
            repeat ($urandom_range(2, 1)) begin
                // destinations stay above the loader's working words
                sec(24'h000202 + $urandom_range(16'hFFFF),
                    $urandom_range(6, 2));
            end
            fin(ent);
        end
        end_of_test();
    end
endmodule
